// file: rtl/fcu_consts.vh
// Constants for the flash check unit: offsets, fields, resets, timing
`ifndef FCU_CONSTS_VH
`define FCU_CONSTS_VH

// ----------------------------------------------------------------------
// Bus and register map
// ----------------------------------------------------------------------
`define FCU_PAW           8
`define FCU_IDX_W         6
`define FCU_IDX_CTRL_1    6'h00
`define FCU_IDX_CTRL_2    6'h01
`define FCU_IDX_STATUS    6'h02
`define FCU_IDX_LAST      6'h02

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FCU_C1_ENABLE     0
`define FCU_C1_FAIL_NMI_ENABLE      1
`define FCU_C1_SRST       7
`define FCU_ST_BUSY       0
`define FCU_ST_OK         1
`define FCU_DBG_BUSY      0
`define FCU_DBG_OK        1

// ----------------------------------------------------------------------
// Field encodings and reset values
// ----------------------------------------------------------------------
`define FCU_SRC_FULL      2'h0
`define FCU_SRC_BOOT_APP  2'h1
`define FCU_SRC_BOOT      2'h2
`define FCU_SRC_NONE      2'h3
`define FCU_MODE_PRIO     2'h0
`define FCU_MODE_INIT     2'h1
`define FCU_OK_RESET      1'h1

// ----------------------------------------------------------------------
// Checksum and timing
// ----------------------------------------------------------------------
`define FCU_AW            17
`define FCU_CRC_POLY      16'h1021
`define FCU_CRC_INIT      16'hFFFF
`define FCU_START_DLY     2'h3
`define FCU_FETCH_LAST    2'h2
`define FCU_WORD_BYTES    17'h0_0002
`define FCU_ADDR_ZERO     17'h0_0000

`endif

// file: rtl/fcu_flash_check_unit.v
// Flash check unit: CRC-16 memory scan with APB registers and debug hooks
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "fcu_consts.vh"

// What this block does
// - Checksum uses CRC-16 polynomial x^16+x^12+x^5+1 over section bytes.
// - Accumulator preset to all ones before the first byte of each check.
// - Bytes fed one at a time from byte 0, most significant bit first.
// - Pass only if last two bytes hold checksum, high byte first.
// - While checking, the unit owns the flash and stalls the CPU.
// - One new 16-bit flash word fetched every third clock cycle.
// - A checksum mismatch clears the check-passed flag.
// - Failed check or debugger pass-flag write 0 with NMI enable raises NMI, held until reset.
// - NMI enable set by writing one, cleared only by system reset.
// - A failed check during reset start-up keeps the chip in reset.
// - After a start-up check: enable one, mode non-zero, section shown.
// - Debugger access suspends the unit; busy check restarts on release.
// - Suspended busy check still reads busy but scans nothing.
// - Synchronised status copy for the debugger; reading it releases.
// - Debugger busy write 0 cancels; write 1 schedules one check.
// - While busy, control second and NMI enable writes are ignored.
// - Debugger pass-flag write 0 may raise NMI; after NMI writes blocked.
// - Debugger pass-flag write 1 reads one while not busy.
// - Debugger control writes follow the same restrictions as CPU writes.
// - Scanner pauses during CPU sleep and continues on wake.
// - Section select: 0 full flash, 1 boot plus code, 2 boot, 3 reserved.
// - Pass flag one after reset, cleared on enable, reads 0 while busy.
// - Enable stays one after a check; rewrite restarts; zero stops later.
// - Soft reset strobe clears control and status next cycle, not NMI enable.
module fcu_flash_check_unit #(
  parameter [16:0] LAST_FLASH_BYTE = 17'h0_FFFF
) (
  // Clock and reset
  input  wire                 pclk,
  input  wire                 presetn,
  // APB slave
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [`FCU_PAW-1:0]  paddr,
  input  wire [31:0]          pwdata,
  input  wire [3:0]           pstrb,
  output reg  [31:0]          prdata,
  output wire                 pready,
  output wire                 pslverr,
  // Program flash port
  output wire                 flash_req,
  output wire [15:0]          flash_addr,
  input  wire [15:0]          flash_rdata,
  // Section boundary fuses
  input  wire [16:0]          boot_end_fuse,
  input  wire [16:0]          app_end_fuse,
  input  wire [1:0]           reset_check_fuse,
  // System side
  input  wire                 init_active,
  input  wire                 cpu_sleep,
  output wire                 cpu_stall,
  output reg                  nmi_req,
  output reg                  chip_hold_reset,
  // Debugger side
  input  wire                 dbg_access,
  input  wire                 dbg_internal,
  input  wire                 dbg_disconnect,
  input  wire                 dbg_status_rd,
  input  wire                 dbg_status_wr,
  input  wire [1:0]           dbg_wdata,
  output reg  [1:0]           dbg_status
);

  // ----------------------------------------------------------------------
  // States
  // ----------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_SCAN = 3'b100;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // CRC-16 generator polynomial
  // One byte through the CRC, MSB first
  function [15:0] fcu_crc_byte;
    input [15:0] crc_in;
    input [7:0]  data;
    integer      i;
    reg   [15:0] r;
    begin
      r = crc_in;
      for (i = 7; i >= 0; i = i - 1) begin
        if (r[15] ^ data[i])
          r = {r[14:0], 1'b0} ^ `FCU_CRC_POLY;
        else
          r = {r[14:0], 1'b0};
      end
      fcu_crc_byte = r;
    end
  endfunction

  // Exclusive end address of the selected section
  function [16:0] fcu_sec_end;
    input [1:0] sel;
    begin
      case (sel)
        `FCU_SRC_BOOT_APP: fcu_sec_end = app_end_fuse;
        `FCU_SRC_BOOT:     fcu_sec_end = boot_end_fuse;
        default:           fcu_sec_end = LAST_FLASH_BYTE + 17'h0_0001;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg [2:0]          state;
  reg                enable;
  reg                fail_nmi_enable;
  reg [1:0]          mode;
  reg [1:0]          src;
  reg                busy;
  reg                ok;
  reg                srst_pend;
  reg                suspended;
  reg                init_run;
  reg                init_seen;
  reg [1:0]          wait_cnt;
  reg [1:0]          fetch_div;
  reg [15:0]         crc;
  reg [`FCU_AW-1:0]  cur_addr;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire [`FCU_IDX_W-1:0] idx = paddr[`FCU_PAW-1:2];
  wire mapped   = (paddr[1:0] == 2'h0) && (idx <= `FCU_IDX_LAST);
  wire apb_wr   = psel & penable & pwrite & pstrb[0] & mapped;
  wire run      = ~cpu_sleep & ~suspended;
  wire release_dbg = dbg_internal | dbg_disconnect | dbg_status_rd;
  wire wr_open  = ~nmi_req;
  // same gating for CPU and debugger control writes
  wire wr_c1    = apb_wr & wr_open & (idx == `FCU_IDX_CTRL_1);
  wire wr_c2    = apb_wr & wr_open & ~busy & (idx == `FCU_IDX_CTRL_2);
  // strobe needs idle when NMI enable is set
  wire srst_go  = wr_c1 & pwdata[`FCU_C1_SRST] & (~fail_nmi_enable | ~busy);
  wire dbg_wr   = dbg_status_wr & wr_open;
  wire fetch    = (state == ST_SCAN) & busy & run &
                  (fetch_div == `FCU_FETCH_LAST);
  wire last_wd  = (cur_addr + `FCU_WORD_BYTES) >= fcu_sec_end(src);
  // high byte at the lower address of the last word
  wire [15:0] stored = {flash_rdata[7:0], flash_rdata[15:8]};
  wire pass     = (crc == stored);
  wire fail_evt = fetch & last_wd & ~pass;
  wire init_go  = init_active & ~init_seen &
                  (reset_check_fuse != `FCU_SRC_NONE);

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign pready     = 1'b1;
  // Unmapped words answer with an error
  assign pslverr    = psel & penable & ~mapped;
  // CPU held while a check owns the flash
  assign cpu_stall  = busy;
  // word fetch request, held high while scanning; address steps every third cycle
  assign flash_req  = (state == ST_SCAN) & busy & run;
  assign flash_addr = cur_addr[15:0];

  // ----------------------------------------------------------------------
  // Register read data, loaded in the setup phase
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= 32'h0000_0000;
      case (idx)
        `FCU_IDX_CTRL_1: begin
          prdata[`FCU_C1_ENABLE] <= enable;
          prdata[`FCU_C1_FAIL_NMI_ENABLE]  <= fail_nmi_enable;
        end
        `FCU_IDX_CTRL_2: begin
          prdata[5:4] <= mode;
          prdata[1:0] <= src;
        end
        `FCU_IDX_STATUS: begin
          prdata[`FCU_ST_BUSY] <= busy;
          // pass flag reads 0 while busy
          prdata[`FCU_ST_OK]   <= ok & ~busy;
        end
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // synchronised status copy for the debugger
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      dbg_status <= 2'h0;
    else
      dbg_status <= {ok & ~busy, busy};
  end

  // ----------------------------------------------------------------------
  // Sequencer, control and status
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state           <= ST_IDLE;
      enable          <= 1'b0;
      fail_nmi_enable           <= 1'b0;
      mode            <= `FCU_MODE_PRIO;
      src             <= `FCU_SRC_FULL;
      busy            <= 1'b0;
      // pass flag set out of reset
      ok              <= `FCU_OK_RESET;
      srst_pend       <= 1'b0;
      suspended       <= 1'b0;
      init_run        <= 1'b0;
      init_seen       <= 1'b0;
      wait_cnt        <= 2'h0;
      fetch_div       <= 2'h0;
      crc             <= `FCU_CRC_INIT;
      cur_addr        <= `FCU_ADDR_ZERO;
      nmi_req         <= 1'b0;
      chip_hold_reset <= 1'b0;
    end else begin
      srst_pend <= srst_go;
      if (dbg_access)
        suspended <= 1'b1;
      else if (release_dbg)
        suspended <= 1'b0;

      if (srst_pend) begin
        // clear control and status, keep NMI enable
        state    <= ST_IDLE;
        enable   <= 1'b0;
        mode     <= `FCU_MODE_PRIO;
        src      <= `FCU_SRC_FULL;
        busy     <= 1'b0;
        ok       <= 1'b0;
        init_run <= 1'b0;
      end else begin
        // Sequencer
        case (state)
          ST_IDLE: begin
            fetch_div <= 2'h0;
          end
          ST_WAIT: begin
            // start delay also pauses in sleep
            if (run) begin
              if (wait_cnt == 2'h1) begin
                state <= ST_SCAN;
                busy  <= 1'b1;
              end
              wait_cnt <= wait_cnt - 2'h1;
            end
          end
          ST_SCAN: begin
            // no progress while asleep or suspended
            if (busy & run) begin
              if (fetch_div == `FCU_FETCH_LAST)
                fetch_div <= 2'h0;
              else
                fetch_div <= fetch_div + 2'h1;
            end
            if (fetch & last_wd) begin
              state <= ST_IDLE;
              busy  <= 1'b0;
              ok    <= pass;
              if (init_run & pass)
                init_run <= 1'b0;
            end else if (fetch) begin
              crc      <= fcu_crc_byte(fcu_crc_byte(crc, flash_rdata[7:0]),
                                       flash_rdata[15:8]);
              cur_addr <= cur_addr + `FCU_WORD_BYTES;
            end
          end
          default: state <= ST_IDLE;
        endcase

        // busy check restarts when the debugger lets go
        if (suspended & release_dbg & busy) begin
          state     <= ST_SCAN;
          fetch_div <= 2'h0;
          crc       <= `FCU_CRC_INIT;
          cur_addr  <= `FCU_ADDR_ZERO;
        end

        // Control first: enable and NMI enable
        if (wr_c1 & ~srst_go) begin
          // zero only clears the bit, the check runs on
          enable <= pwdata[`FCU_C1_ENABLE];
          // NMI enable set-only, locked while busy
          if (pwdata[`FCU_C1_FAIL_NMI_ENABLE] & ~busy)
            fail_nmi_enable <= 1'b1;
          // start three cycles after enable, flag cleared
          if (pwdata[`FCU_C1_ENABLE] & ~busy) begin
            state    <= ST_WAIT;
            wait_cnt <= `FCU_START_DLY;
            ok       <= 1'b0;
            // accumulator preset for the new check
            crc      <= `FCU_CRC_INIT;
            cur_addr <= `FCU_ADDR_ZERO;
          end
        end

        if (wr_c2 & ~srst_go) begin
          mode <= pwdata[5:4];
          src  <= pwdata[1:0];
        end

        // Debugger writes to status
        if (dbg_wr) begin
          if (!dbg_wdata[`FCU_DBG_BUSY]) begin
            busy  <= 1'b0;
            state <= ST_IDLE;
          end else begin
            // schedule one check with current settings
            busy      <= 1'b1;
            state     <= ST_SCAN;
            fetch_div <= 2'h0;
            crc       <= `FCU_CRC_INIT;
            cur_addr  <= `FCU_ADDR_ZERO;
          end
          if (dbg_wdata[`FCU_DBG_OK] & ~busy)
            ok <= 1'b1;
          else if (!dbg_wdata[`FCU_DBG_OK])
            ok <= 1'b0;
        end

        // start-up check loads its settings once
        if (init_go) begin
          init_seen <= 1'b1;
          init_run  <= 1'b1;
          enable    <= 1'b1;
          mode      <= `FCU_MODE_INIT;
          src       <= reset_check_fuse;
          state     <= ST_SCAN;
          busy      <= 1'b1;
          ok        <= 1'b0;
          fetch_div <= 2'h0;
          crc       <= `FCU_CRC_INIT;
          cur_addr  <= `FCU_ADDR_ZERO;
        end
      end

      if (fail_evt & ~srst_pend)
        ok <= 1'b0;
      if (fail_nmi_enable & (fail_evt | (dbg_wr & ~dbg_wdata[`FCU_DBG_OK])))
        nmi_req <= 1'b1;
      // failed start-up check holds the chip in reset
      if (fail_evt & init_run)
        chip_hold_reset <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: tb/fcu_flash_check_unit_sva.sv
// Checker: port-level assertions for the flash check unit
`timescale 1ns/1ps
`default_nettype none
module fcu_flash_check_unit_sva (
  // Clock, reset and APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Flash, system and debug
  input wire logic        flash_req,
  input wire logic [15:0] flash_addr,
  input wire logic        init_active,
  input wire logic        cpu_sleep,
  input wire logic        cpu_stall,
  input wire logic        nmi_req,
  input wire logic        chip_hold_reset,
  input wire logic        dbg_access,
  input wire logic        dbg_status_rd,
  input wire logic        dbg_status_wr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0]  hcnt;
  logic [15:0] laddr;
  logic        lval;
  logic        start;

  // Cycles the current fetch address has been held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt  <= 4'h0;
      laddr <= 16'h0000;
      lval  <= 1'b0;
    end else if (dbg_access || dbg_status_rd || !cpu_stall) begin
      hcnt  <= 4'h0;
      lval  <= 1'b0;
    end else if (flash_req) begin
      hcnt  <= (lval && flash_addr == laddr) ? hcnt + 4'h1 : 4'h1;
      laddr <= flash_addr;
      lval  <= 1'b1;
    end
  end
  // Software enable write that must start a check
  assign start = psel && penable && pwrite && paddr == 8'h00 && pwdata[0]
                 && !pwdata[7] && !cpu_stall && !nmi_req && !cpu_sleep;

  property p_fetch_hold;
    flash_req && lval && flash_addr != laddr |-> hcnt == 4'h3;
  endproperty
  a_fetch_hold: assert property (p_fetch_hold) else $error("fetch period");
  property p_stall;
    flash_req |-> cpu_stall;
  endproperty
  a_stall: assert property (p_stall) else $error("flash use w/o stall");
  property p_start;
    start |=> !cpu_stall ##1 !cpu_stall ##[1:2] (cpu_stall && flash_req);
  endproperty
  a_start: assert property (p_start) else $error("start delay wrong");
  property p_busy_rd;
    psel && !penable && !pwrite && paddr == 8'h08 && cpu_stall
      |=> prdata[1:0] == 2'b01;
  endproperty
  a_busy_rd: assert property (p_busy_rd) else $error("busy status");
  property p_nmi_hold;
    nmi_req |=> nmi_req;
  endproperty
  a_nmi_hold: assert property (p_nmi_hold) else $error("nmi dropped");
  property p_hold_init;
    $rose(chip_hold_reset) |-> $past(init_active);
  endproperty
  a_hold_init: assert property (p_hold_init) else $error("hold w/o init");
  property p_sleep;
    cpu_sleep && cpu_stall |-> !flash_req ##1 cpu_stall;
  endproperty
  a_sleep: assert property (p_sleep) else $error("scan during sleep");
  property p_suspend;
    dbg_access && cpu_stall && !dbg_status_wr |=> cpu_stall && !flash_req;
  endproperty
  a_suspend: assert property (p_suspend) else $error("no suspend");
  property p_resume;
    dbg_status_rd && cpu_stall && !cpu_sleep |-> ##[1:4] flash_req;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume");
endmodule
`default_nettype wire

// file: tb/fcu_flash_check_unit_tb.sv
// Testbench: self-checking run of the flash check unit
`timescale 1ns/1ps
`default_nettype none
module fcu_flash_check_unit_tb;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic        pready, pslverr, e, flash_req, cpu_stall, nmi_req, hold;
  logic [15:0] flash_addr, flash_rdata;
  logic        init_active = 1, cpu_sleep = 0, corrupt = 0;
  logic        dbg_access = 0, dbg_internal = 0, dbg_status_rd = 0;
  logic        dbg_status_wr = 0, dbg_disconnect = 0;
  logic [1:0]  dbg_wdata = 2'h0, dbg_status;
  int          error_cnt = 0, check_count = 0;

  always #25 pclk = ~pclk;

  fcu_flash_check_unit #(.LAST_FLASH_BYTE(17'h0_003F)) fcu_flash_check_unit_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_req(flash_req), .flash_addr(flash_addr),
    .flash_rdata(flash_rdata), .boot_end_fuse(17'h0_0010),
    .app_end_fuse(17'h0_0020), .reset_check_fuse(2'h2),
    .init_active(init_active), .cpu_sleep(cpu_sleep),
    .cpu_stall(cpu_stall), .nmi_req(nmi_req), .chip_hold_reset(hold),
    .dbg_access(dbg_access), .dbg_internal(dbg_internal),
    .dbg_disconnect(dbg_disconnect), .dbg_status_rd(dbg_status_rd),
    .dbg_status_wr(dbg_status_wr), .dbg_wdata(dbg_wdata),
    .dbg_status(dbg_status));
  fcu_flash_model fcu_flash_model_i (.flash_req(flash_req),
    .flash_addr(flash_addr), .corrupt(corrupt), .flash_rdata(flash_rdata));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string n);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // APB transfer, held until pready at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input string n);
    apb(1'b0, a, 8'h00);
    chk(r, x, n);
  endtask
  task wait_done;
    repeat (6) @(posedge pclk);
    while (cpu_stall !== 1'b0) @(posedge pclk);
  endtask
  // section first, mode zero, then enable
  task start(input logic [1:0] sec);
    apb(1'b1, 8'h04, {6'h00, sec});
    apb(1'b1, 8'h00, 8'h01);
  endtask
  task reset_dut(input logic init);
    @(posedge pclk);
    presetn     <= 1'b0;
    init_active <= init;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task t_init_pass;
    reset_dut(1'b1);
    wait_done;
    init_active <= 1'b0;
    chk(hold, 1'b0, "hold");
    rd(8'h00, 32'h01, "ctrl1");
    rd(8'h04, 32'h12, "ctrl2");
  endtask
  task t_sections;
    for (int s = 0; s < 3; s++) begin
      start(s[1:0]);
      wait_done;
      rd(8'h08, 32'h02, "status");
    end
    rd(8'h00, 32'h01, "ctrl1");
    rd(8'h0C, 32'h00, "unmapped");
    chk(e, 1'b1, "pslverr");
  endtask
  task t_busy_sleep;
    start(2'h1);
    repeat (6) @(posedge pclk);
    apb(1'b1, 8'h04, 8'h02);
    rd(8'h04, 32'h01, "ctrl2");
    cpu_sleep <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(flash_req, 1'b0, "req");
    cpu_sleep <= 1'b0;
    wait_done;
    rd(8'h08, 32'h02, "status");
  endtask
  task t_debug;
    start(2'h0);
    repeat (10) @(posedge pclk);
    dbg_access <= 1'b1;
    @(posedge pclk);
    dbg_access <= 1'b0;
    rd(8'h08, 32'h01, "status");
    dbg_status_rd <= 1'b1;
    @(posedge pclk);
    dbg_status_rd <= 1'b0;
    wait_done;
    rd(8'h08, 32'h02, "status");
    start(2'h0);
    repeat (10) @(posedge pclk);
    dbg_access    <= 1'b1;
    dbg_status_wr <= 1'b1;
    @(posedge pclk);
    dbg_access    <= 1'b0;
    dbg_status_wr <= 1'b0;
    dbg_internal  <= 1'b1;
    @(posedge pclk);
    dbg_internal <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(cpu_stall, 1'b0, "stall");
    dbg_wdata     <= 2'h2;
    dbg_status_wr <= 1'b1;
    @(posedge pclk);
    dbg_status_wr <= 1'b0;
    rd(8'h08, 32'h02, "status");
    dbg_wdata     <= 2'h1;
    dbg_access    <= 1'b1;
    dbg_status_wr <= 1'b1;
    @(posedge pclk);
    dbg_access    <= 1'b0;
    dbg_status_wr <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(8'h08, 32'h01, "status");
    chk(dbg_status, 2'h1, "dbg_status");
    dbg_disconnect <= 1'b1;
    @(posedge pclk);
    dbg_disconnect <= 1'b0;
    wait_done;
    rd(8'h08, 32'h02, "status");
  endtask
  task t_soft_nmi;
    apb(1'b1, 8'h00, 8'h80);
    rd(8'h04, 32'h00, "ctrl2");
    rd(8'h08, 32'h00, "status");
    reset_dut(1'b0);
    rd(8'h08, 32'h02, "status");
    corrupt <= 1'b1;
    apb(1'b1, 8'h00, 8'h02);
    rd(8'h00, 32'h02, "ctrl1");
    start(2'h2);
    wait_done;
    rd(8'h08, 32'h00, "status");
    chk(nmi_req, 1'b1, "nmi");
    apb(1'b1, 8'h00, 8'h80);
    rd(8'h00, 32'h03, "ctrl1");
    reset_dut(1'b1);
    wait_done;
    repeat (3) @(posedge pclk);
    chk(hold, 1'b1, "hold");
  endtask

  // Watchdog against a hung handshake or scan
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    report_and_stop;
  end
  // Main sequence
  initial begin
    t_init_pass;
    t_sections;
    t_busy_sleep;
    t_debug;
    t_soft_nmi;
    report_and_stop;
  end
endmodule
bind fcu_flash_check_unit fcu_flash_check_unit_sva fcu_flash_check_unit_sva_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .flash_req(flash_req), .flash_addr(flash_addr),
  .init_active(init_active), .cpu_sleep(cpu_sleep),
  .cpu_stall(cpu_stall), .nmi_req(nmi_req),
  .chip_hold_reset(chip_hold_reset), .dbg_access(dbg_access),
  .dbg_status_rd(dbg_status_rd), .dbg_status_wr(dbg_status_wr));
`default_nettype wire

// file: tb/fcu_flash_model.sv
// Flash model: byte image with stored section checksums
`timescale 1ns/1ps
`default_nettype none
module fcu_flash_model (
  // Fetch port and fault control
  input  wire logic        flash_req,
  input  wire logic [15:0] flash_addr,
  input  wire logic        corrupt,
  output logic      [15:0] flash_rdata
);
  logic [7:0]  mem [0:63];
  logic [15:0] word;

  function automatic logic [15:0] crc(input int n);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < n; i++)
      for (int b = 7; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ mem[i][b]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction

  initial begin
    for (int i = 0; i < 64; i++)
      mem[i] = 8'(i * 37 + 11);
    for (int e = 16; e <= 64; e = e * 2)
      {mem[e-2], mem[e-1]} = crc(e - 2);
  end
  // Fault flips bit 0 of boot byte 4; idle port shows inverted data
  always_comb begin
    word = {mem[flash_addr[5:0] | 6'h01], mem[flash_addr[5:0]]};
    if (corrupt && flash_addr[5:0] == 6'h04)
      word[0] = ~word[0];
    flash_rdata = flash_req ? word : ~word;
  end
endmodule
`default_nettype wire
